/* File: hdl/frc_dev.sv */
// Device end: reset pair, unique id read and parameter-area read
`timescale 1ns/1ps
`default_nettype none
`include "frc_consts.svh"
module frc_dev #(
    parameter logic [7:0] UID_OPCODE = `FRC_OP_UID_DFLT,
    // Arbitrary neutral value
    parameter logic [7:0] VENDOR_ID = `FRC_VENDOR_DFLT,
    // Arbitrary per-part value
    parameter logic [127:0] UID_VALUE = `FRC_UID_DFLT
) (
    input wire logic mclk,
    input wire logic arst_n,
    frc_link_if.dev link,
    input wire logic prog_busy,
    output logic soft_reset,
    output logic op_abort,
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic armed
);
    // ------------------------------------------------------------------
    // Link domain declarations
    // ------------------------------------------------------------------
    logic [5:0] cnt_reg;
    logic [6:0] sh_reg;
    frc_pkg::frc_cmd_e cmd_reg;
    logic [23:0] addr_reg;
    logic [2:0] bit_reg;
    logic arm_reg;
    logic rst_tgl_reg;
    logic opc_tgl_reg;
    logic [7:0] opc_hold_reg;
    logic so_reg;
    logic oe_reg;

    wire logic frame_rst_n;
    wire logic [7:0] opc;
    wire logic opc_done;
    wire logic addr_phase;
    wire logic data_phase;
    wire logic out_cmd;
    wire logic rst_fire;
    wire logic arm_next;
    wire logic [7:0] rom_byte;
    wire logic [7:0] uid_byte;
    wire logic [7:0] out_byte;
    frc_pkg::frc_cmd_e dec_cmd;
    logic [7:0] uid_bytes [16];

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Chip select high clears the frame at once, serial clock may be stopped
    assign frame_rst_n = arst_n & ~link.cs_n;
    // Opcode taken from the serial input alone
    assign opc = {sh_reg, link.si}; // RL3
    assign opc_done = cnt_reg == (`FRC_OPC_BITS - 6'h01);
    assign addr_phase = (cmd_reg == frc_pkg::CMD_PARAM) && (cnt_reg >= `FRC_OPC_BITS)
                        && (cnt_reg < `FRC_ADDR_END); // RL7
    assign data_phase = cnt_reg == `FRC_LEAD_BITS; // RL6 RL7
    assign out_cmd = (cmd_reg == frc_pkg::CMD_PARAM) || (cmd_reg == frc_pkg::CMD_UID);

    always_comb begin
        if (opc == `FRC_OP_PARAM) begin
            dec_cmd = frc_pkg::CMD_PARAM;
        end else if (opc == UID_OPCODE) begin
            dec_cmd = frc_pkg::CMD_UID; // RL15
        end else begin
            dec_cmd = frc_pkg::CMD_OTHER;
        end
    end

    // Reset fires only on an armed reset opcode; any complete opcode other than arm disarms
    assign rst_fire = opc_done && (opc == `FRC_OP_RST) && arm_reg; // RL1 RL2
    assign arm_next = opc_done ? (opc == `FRC_OP_ARM) : arm_reg; // RL2 RL14

    // ------------------------------------------------------------------
    // Output data selection
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_uid
            // First byte out is the top byte of the identifier
            assign uid_bytes[gi] = UID_VALUE[127 - 8 * gi -: 8]; // RL5
        end
    endgenerate

    assign uid_byte = uid_bytes[addr_reg[3:0]];
    assign out_byte = (cmd_reg == frc_pkg::CMD_UID) ? uid_byte : rom_byte;

    frc_hdr_rom #(
        .VENDOR_ID(VENDOR_ID)
    ) u_rom (
        .addr(addr_reg),
        .data(rom_byte)
    );

    // ------------------------------------------------------------------
    // Frame state, rising edge of the serial clock
    // ------------------------------------------------------------------
    always_ff @(posedge link.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            cnt_reg <= 6'h00;
            sh_reg <= 7'h00;
            cmd_reg <= frc_pkg::CMD_IDLE;
        end else begin
            sh_reg <= opc[6:0];
            if (!data_phase) begin
                cnt_reg <= cnt_reg + 6'h01;
            end
            if (opc_done) begin
                cmd_reg <= dec_cmd;
            end
        end
    end

    // Address runs on through the area; id reads start at byte 0 and wrap
    always_ff @(posedge link.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            addr_reg <= 24'h00_0000;
            bit_reg <= 3'h0;
        end else if (addr_phase) begin
            addr_reg <= {addr_reg[22:0], link.si}; // RL7
        end else if (data_phase) begin
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
                addr_reg <= addr_reg + 24'h00_0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Arm flag and events, kept across frames
    // ------------------------------------------------------------------
    always_ff @(posedge link.sclk or negedge arst_n) begin
        if (!arst_n) begin
            arm_reg <= 1'b0;
            rst_tgl_reg <= 1'b0;
            opc_tgl_reg <= 1'b0;
            opc_hold_reg <= 8'h00;
        end else begin
            arm_reg <= arm_next;
            if (rst_fire) begin
                rst_tgl_reg <= ~rst_tgl_reg; // RL1
            end
            // Held stable for a whole byte, long enough for the crossing
            if (opc_done) begin
                opc_tgl_reg <= ~opc_tgl_reg;
                opc_hold_reg <= opc;
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial output, falling edge so the host samples on the rising one
    // ------------------------------------------------------------------
    always_ff @(negedge link.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            so_reg <= 1'b0; // RL8
            oe_reg <= 1'b0; // RL8
        end else begin
            oe_reg <= data_phase && out_cmd; // RL6 RL7
            so_reg <= out_byte[3'h7 - bit_reg]; // RL15
        end
    end

    assign link.so_out = so_reg;
    assign link.so_oe = oe_reg;

    // ------------------------------------------------------------------
    // Crossing to the system clock
    // ------------------------------------------------------------------
    logic rst_s1_reg;
    logic rst_s2_reg;
    logic rst_s3_reg;
    logic opc_s1_reg;
    logic opc_s2_reg;
    logic opc_s3_reg;
    logic arm_s1_reg;
    logic arm_s2_reg;
    logic soft_reset_reg;
    logic op_abort_reg;
    logic cmd_valid_reg;
    logic [7:0] cmd_opcode_reg;
    wire logic rst_evt;
    wire logic opc_evt;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
            rst_s3_reg <= 1'b0;
            opc_s1_reg <= 1'b0;
            opc_s2_reg <= 1'b0;
            opc_s3_reg <= 1'b0;
            arm_s1_reg <= 1'b0;
            arm_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= rst_tgl_reg;
            rst_s2_reg <= rst_s1_reg;
            rst_s3_reg <= rst_s2_reg;
            opc_s1_reg <= opc_tgl_reg;
            opc_s2_reg <= opc_s1_reg;
            opc_s3_reg <= opc_s2_reg;
            arm_s1_reg <= arm_reg;
            arm_s2_reg <= arm_s1_reg;
        end
    end

    assign rst_evt = rst_s2_reg ^ rst_s3_reg;
    assign opc_evt = opc_s2_reg ^ opc_s3_reg;

    // ------------------------------------------------------------------
    // System side outputs
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            soft_reset_reg <= 1'b0;
            op_abort_reg <= 1'b0;
            cmd_valid_reg <= 1'b0;
            cmd_opcode_reg <= 8'h00;
        end else begin
            soft_reset_reg <= rst_evt; // RL1
            // Array contents under work may be left damaged
            op_abort_reg <= rst_evt && prog_busy; // RL4
            cmd_valid_reg <= opc_evt;
            if (opc_evt) begin
                cmd_opcode_reg <= opc_hold_reg;
            end
        end
    end

    assign soft_reset = soft_reset_reg;
    assign op_abort = op_abort_reg;
    assign cmd_valid = cmd_valid_reg;
    assign cmd_opcode = cmd_opcode_reg;
    assign armed = arm_s2_reg;
endmodule // frc_dev
`default_nettype wire

/* File: hdl/frc_consts.svh */
// Constants for the flash reset, unique id and parameter-area command block
// Function
// RL1: Arm command then reset command restores defaults
// RL2: Any other command cancels arm; reset ignored
// RL3: Upper data lines ignored during reset commands
// RL4: Accepted reset aborts running program or erase
// RL5: Fixed read-only 128-bit per-part identifier
// RL6: Id read: opcode, four dummy bytes, id
// RL7: Parameter read: 5Ah, address, dummy, data
// RL8: Chip select rise ends read, output released
// RL9: Bytes 00h-03h give signature, LSB first
// RL10: Bytes 04h-06h give revisions and header count
// RL11: First header: standard table, pointer 30h
// RL12: Second header: vendor id, pointer 60h
// RL13: Bytes 07h, 0Fh, 17h read FFh
// RL14: No-effect command only cancels pending arm
// RL15: Id opcode is parameter; MSB first out
`ifndef FRC_CONSTS_SVH
`define FRC_CONSTS_SVH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define FRC_OP_ARM 8'h66
`define FRC_OP_RST 8'h99
`define FRC_OP_NOP 8'h00
`define FRC_OP_PARAM 8'h5A
`define FRC_OP_UID_DFLT 8'h4B

// ----------------------------------------------------------------------
// Frame layout, in serial clock rising edges
// ----------------------------------------------------------------------
`define FRC_OPC_BITS 6'h08
`define FRC_ADDR_END 6'h20
`define FRC_LEAD_BITS 6'h28
`define FRC_DUMMY_BYTE 8'h00

// ----------------------------------------------------------------------
// Header table, one double word each, byte 0 in bits 7:0
// ----------------------------------------------------------------------
`define FRC_HDR_DW0 32'h5044_4653
`define FRC_HDR_DW1 32'hFF01_0100
`define FRC_HDR_DW2 32'h0901_0000
`define FRC_HDR_DW3 32'hFF00_0030
`define FRC_HDR_DW4_HI 24'h03_0100
`define FRC_HDR_DW5 32'hFF00_0060
`define FRC_HDR_END 24'h00_0018
`define FRC_UNMAPPED_BYTE 8'hFF

// ----------------------------------------------------------------------
// Identity defaults and host timing
// ----------------------------------------------------------------------
`define FRC_VENDOR_DFLT 8'hA5
`define FRC_UID_DFLT 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
`define FRC_HALF_CYC 3'h4
`define FRC_UPPER_IDLE 3'h7

`endif

/* File: hdl/frc_pkg.sv */
// Types shared by both ends of the flash command link
`default_nettype none
package frc_pkg;
    typedef enum logic [1:0] {CMD_IDLE, CMD_PARAM, CMD_UID, CMD_OTHER} frc_cmd_e;
    typedef enum logic [1:0] {KIND_OPCODE, KIND_PARAM, KIND_UID} frc_kind_e;
    typedef enum logic [1:0] {H_IDLE, H_SETUP, H_RUN, H_HOLD} frc_hst_e;
endpackage
`default_nettype wire

/* File: hdl/frc_link_if.sv */
// Serial link between host controller and flash command front end
`timescale 1ns/1ps
`default_nettype none
interface frc_link_if;
    logic cs_n;
    logic sclk;
    logic si;
    logic [3:1] upper_data_lines;
    logic so_out;
    logic so_oe;
    logic so_line;

    // Released output line idles high
    assign so_line = so_oe ? so_out : 1'b1;

    modport dev (
        input cs_n,
        input sclk,
        input si,
        input upper_data_lines,
        output so_out,
        output so_oe
    );

    modport host (
        output cs_n,
        output sclk,
        output si,
        output upper_data_lines,
        input so_line
    );
endinterface
`default_nettype wire

/* File: hdl/frc_hdr_rom.sv */
// Fixed parameter-area header table lookup
`timescale 1ns/1ps
`default_nettype none
`include "frc_consts.svh"
module frc_hdr_rom #(
    // Arbitrary neutral value
    parameter logic [7:0] VENDOR_ID = `FRC_VENDOR_DFLT
) (
    input wire logic [23:0] addr,
    output logic [7:0] data
);
    logic [31:0] dw;
    wire logic in_hdr;
    wire logic [31:0] dw_shift;

    always_comb begin
        unique case (addr[4:2])
            3'h0: dw = `FRC_HDR_DW0; // RL9 RL10
            3'h1: dw = `FRC_HDR_DW1; // RL10 RL13
            3'h2: dw = `FRC_HDR_DW2; // RL11
            3'h3: dw = `FRC_HDR_DW3; // RL11 RL13
            3'h4: dw = {`FRC_HDR_DW4_HI, VENDOR_ID}; // RL12
            3'h5: dw = `FRC_HDR_DW5; // RL12 RL13
            default: dw = {4{`FRC_UNMAPPED_BYTE}};
        endcase
    end

    // Tables past the header are not held here and read as erased
    assign in_hdr = addr < `FRC_HDR_END;
    assign dw_shift = dw >> {addr[1:0], 3'h0};
    assign data = in_hdr ? dw_shift[7:0] : `FRC_UNMAPPED_BYTE;
endmodule // frc_hdr_rom
`default_nettype wire

/* File: hdl/frc_host.sv */
// Host end: serial controller issuing opcode, id and parameter-area frames
`timescale 1ns/1ps
`default_nettype none
`include "frc_consts.svh"
module frc_host #(
    parameter logic [7:0] UID_OPCODE = `FRC_OP_UID_DFLT
) (
    input wire logic mclk,
    input wire logic arst_n,
    frc_link_if.host link,
    input wire logic start,
    input wire frc_pkg::frc_kind_e kind,
    input wire logic [7:0] opcode,
    input wire logic [23:0] addr,
    input wire logic [7:0] rx_len,
    input wire logic stop_req,
    output logic busy,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic done
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    frc_pkg::frc_hst_e st_reg;
    logic [2:0] div_reg;
    logic sclk_reg;
    logic cs_n_reg;
    logic si_reg;
    logic [39:0] tx_reg;
    logic [11:0] cnt_reg;
    logic [11:0] txb_reg;
    logic [11:0] total_reg;
    logic [2:0] rxbit_reg;
    logic [7:0] rx_sh_reg;
    logic [7:0] rx_byte_reg;
    logic rx_valid_reg;
    logic done_reg;
    logic busy_reg;
    logic [2:0] upper_reg;
    logic so_s1_reg;
    logic so_s2_reg;

    wire logic tick;
    wire logic long_frame;
    wire logic [39:0] tx_load;
    wire logic [11:0] txb_load;
    wire logic [11:0] total_load;
    wire logic rx_bit;
    wire logic [7:0] rx_in;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign tick = div_reg == (`FRC_HALF_CYC - 3'h1);
    assign long_frame = kind != frc_pkg::KIND_OPCODE;
    // Arm and reset go out as two single-opcode frames
    assign tx_load = (kind == frc_pkg::KIND_PARAM) ?
                     {`FRC_OP_PARAM, addr, `FRC_DUMMY_BYTE} : // RL7
                     (kind == frc_pkg::KIND_UID) ?
                     {UID_OPCODE, {4{`FRC_DUMMY_BYTE}}} : // RL6
                     {opcode, {4{`FRC_DUMMY_BYTE}}}; // RL1
    assign txb_load = long_frame ? {6'h00, `FRC_LEAD_BITS} : {6'h00, `FRC_OPC_BITS};
    assign total_load = txb_load + {1'b0, rx_len, 3'h0};
    assign rx_bit = cnt_reg >= txb_reg;
    // Data arrives most significant bit first
    assign rx_in = {rx_sh_reg[6:0], so_s2_reg}; // RL15

    // ------------------------------------------------------------------
    // Input synchroniser and clock divider
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            so_s1_reg <= 1'b1;
            so_s2_reg <= 1'b1;
            div_reg <= 3'h0;
            upper_reg <= `FRC_UPPER_IDLE;
        end else begin
            so_s1_reg <= link.so_line;
            so_s2_reg <= so_s1_reg;
            div_reg <= (st_reg == frc_pkg::H_IDLE || tick) ? 3'h0 : div_reg + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= frc_pkg::H_IDLE;
            sclk_reg <= 1'b0;
            cs_n_reg <= 1'b1;
            si_reg <= 1'b0;
            tx_reg <= 40'h00_0000_0000;
            cnt_reg <= 12'h000;
            txb_reg <= 12'h000;
            total_reg <= 12'h000;
            rxbit_reg <= 3'h0;
            rx_sh_reg <= 8'h00;
            rx_byte_reg <= 8'h00;
            rx_valid_reg <= 1'b0;
            done_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            rx_valid_reg <= 1'b0;
            done_reg <= 1'b0;
            unique case (st_reg)
                frc_pkg::H_IDLE: begin
                    if (start) begin
                        st_reg <= frc_pkg::H_SETUP;
                        cs_n_reg <= 1'b0;
                        busy_reg <= 1'b1;
                        tx_reg <= tx_load;
                        si_reg <= tx_load[39];
                        txb_reg <= txb_load;
                        total_reg <= total_load;
                        cnt_reg <= 12'h000;
                        rxbit_reg <= 3'h0;
                    end
                end
                frc_pkg::H_SETUP: begin
                    if (tick) begin
                        st_reg <= frc_pkg::H_RUN;
                    end
                end
                frc_pkg::H_RUN: begin
                    if (stop_req) begin
                        // Early end during data out is allowed
                        st_reg <= frc_pkg::H_HOLD; // RL8
                        cs_n_reg <= 1'b1; // RL8
                        sclk_reg <= 1'b0;
                    end else if (tick && !sclk_reg) begin
                        sclk_reg <= 1'b1;
                        cnt_reg <= cnt_reg + 12'h001;
                        if (rx_bit) begin
                            rx_sh_reg <= rx_in;
                            rxbit_reg <= rxbit_reg + 3'h1;
                            if (rxbit_reg == 3'h7) begin
                                rx_byte_reg <= rx_in;
                                rx_valid_reg <= 1'b1;
                            end
                        end
                    end else if (tick) begin
                        sclk_reg <= 1'b0;
                        if (cnt_reg == total_reg) begin
                            st_reg <= frc_pkg::H_HOLD;
                            cs_n_reg <= 1'b1; // RL6
                        end else begin
                            tx_reg <= {tx_reg[38:0], 1'b0};
                            si_reg <= tx_reg[38];
                        end
                    end
                end
                frc_pkg::H_HOLD: begin
                    if (tick) begin
                        st_reg <= frc_pkg::H_IDLE;
                        busy_reg <= 1'b0;
                        done_reg <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign link.cs_n = cs_n_reg;
    assign link.sclk = sclk_reg;
    assign link.si = si_reg;
    assign link.upper_data_lines = upper_reg;
    assign busy = busy_reg;
    assign rx_valid = rx_valid_reg;
    assign rx_byte = rx_byte_reg;
    assign done = done_reg;
endmodule // frc_host
`default_nettype wire

/* File: sim/frc_link_monitor.sv */
// Protocol checker for the flash command link
`timescale 1ns/1ps
`default_nettype none
module frc_link_monitor (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic [3:1] upper_data_lines,
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic so_line
);
    // ------------------------------------------------------------
    // Rising edges of the link clock in the current frame
    // ------------------------------------------------------------
    logic sclk_reg;
    logic [7:0] rises_reg;
    logic [7:0] rises_next;
    assign rises_next = cs_n ? 8'h00 : rises_reg + {7'h00, sclk & ~sclk_reg};
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_reg <= 1'b0;
            rises_reg <= 8'h00;
        end else begin
            sclk_reg <= sclk;
            rises_reg <= rises_next;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    chk_oe_idle_cs: assert property (cs_n |-> !so_oe)
        else $error("output driven while deselected");
    chk_line_released: assert property (!so_oe |-> so_line)
        else $error("released output line not high");
    chk_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("link clock moving outside a frame");
    chk_upper_lines_idle: assert property (upper_data_lines == 3'h7)
        else $error("upper data lines not idle");
    chk_oe_after_lead: assert property ($rose(so_oe) |-> !sclk && rises_reg == 8'h28)
        else $error("output enabled at wrong bit count");
    chk_no_early_drive: assert property (rises_reg < 8'h28 |-> !so_oe)
        else $error("output driven during command phase");
    chk_so_bit_stands: assert property (so_oe && sclk && $past(sclk) |-> $stable(so_out))
        else $error("output bit changed while clock high");
    chk_si_bit_stands: assert property (sclk && $past(sclk) |-> $stable(si))
        else $error("input bit changed while clock high");
    chk_frame_lead: assert property ($fell(cs_n) |-> !sclk[*3] ##[1:12] sclk)
        else $error("frame lead-in wrong");
    cover property ($rose(so_oe));
    cover property ($rose(cs_n) && $past(so_oe));
    cover property ($rose(cs_n) && rises_reg == 8'h08);
endmodule // frc_link_monitor
`default_nettype wire

/* File: sim/flash_reset_uid_sfdp_cmds_tb_top.sv */
// Self-checking bench joining host and device ends of the link
`timescale 1ns/1ps
`default_nettype none
`include "frc_consts.svh"
module flash_reset_uid_sfdp_cmds_tb_top;
    // Arbitrary neutral identity values
    localparam logic [7:0] VEND = 8'h5C;
    localparam logic [127:0] UIDV = 128'hC0DE_1234_5678_9ABC_DEF0_0F1E_2D3C_4B5A;
    localparam logic [7:0] UID_OP = 8'h4B;
    localparam logic [7:0] CANCEL [4] = '{8'h00, 8'h4B, 8'h5A, 8'h9F};
    logic mclk, arst_n, prog_busy, soft_reset, op_abort, cmd_valid, armed;
    logic start, stop_req, busy, rx_valid, done;
    logic [7:0] cmd_opcode, opcode, rx_len, rx_byte;
    logic [23:0] addr;
    frc_pkg::frc_kind_e kind;
    logic [7:0] exp_q[$];
    int miscompares, comparisons, n_rst, n_abort, n_cmd, rnd;
    frc_link_if lnk();
    frc_dev #(.UID_OPCODE(UID_OP), .VENDOR_ID(VEND), .UID_VALUE(UIDV)) i_frc_dev (
        .mclk(mclk), .arst_n(arst_n), .link(lnk.dev), .prog_busy(prog_busy),
        .soft_reset(soft_reset), .op_abort(op_abort), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .armed(armed));
    frc_host #(.UID_OPCODE(UID_OP)) i_frc_host (
        .mclk(mclk), .arst_n(arst_n), .link(lnk.host), .start(start), .kind(kind),
        .opcode(opcode), .addr(addr), .rx_len(rx_len), .stop_req(stop_req),
        .busy(busy), .rx_valid(rx_valid), .rx_byte(rx_byte), .done(done));
    frc_link_monitor i_frc_link_monitor (
        .mclk(mclk), .arst_n(arst_n), .cs_n(lnk.cs_n), .sclk(lnk.sclk), .si(lnk.si),
        .upper_data_lines(lnk.upper_data_lines), .so_out(lnk.so_out),
        .so_oe(lnk.so_oe), .so_line(lnk.so_line));
    // ------------------------------------------------------------
    // Clock, checks and verdict
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        comparisons++;
        if (seen !== expd) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expd);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Header bytes, byte 0 in the low bits; past the header reads FFh
    function automatic logic [7:0] pbyte(input logic [23:0] a);
        logic [191:0] t;
        t = {56'hFF_0000_6003_0100, VEND, 64'hFF00_0030_0901_0000, 64'hFF01_0100_5044_4653};
        return (a < 24'h00_0018) ? t[8*a[4:0] +: 8] : 8'hFF;
    endfunction
    // ------------------------------------------------------------
    // Frame driver; stop_at nonzero ends the frame after that many bytes
    // ------------------------------------------------------------
    task automatic frame(input frc_pkg::frc_kind_e k, input logic [7:0] op,
        input logic [23:0] a, input logic [7:0] n, input int stop_at);
        int got;
        got = 0;
        @(posedge mclk);
        #1;
        start = 1'b1;
        kind = k;
        opcode = op;
        addr = a;
        rx_len = n;
        @(posedge mclk);
        #1;
        start = 1'b0;
        check(busy, 1'b1);
        for (int i = 0; i < 4000 && done !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
            if (rx_valid === 1'b1) got++;
            if (stop_at != 0 && got >= stop_at) stop_req = 1'b1;
        end
        stop_req = 1'b0;
        check(done, 1'b1);
        check(busy, 1'b0);
        repeat (16) @(posedge mclk);
        #1;
    endtask
    always @(negedge mclk) begin
        if (rx_valid === 1'b1) begin
            check(rx_byte, exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx);
        end
        if (soft_reset === 1'b1) n_rst++;
        if (cmd_valid === 1'b1) n_cmd++;
        if (op_abort === 1'b1) n_abort++;
    end
    initial begin
        repeat (30000) @(posedge mclk);
        miscompares++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        logic [23:0] ra;
        {prog_busy, start, stop_req, arst_n} = 4'h0;
        kind = frc_pkg::KIND_OPCODE;
        opcode = 8'h00;
        addr = 24'h00_0000;
        rx_len = 8'h00;
        rnd = $urandom(97101);
        repeat (16) @(posedge mclk);
        #1;
        arst_n = 1'b1;
        // Whole header and two bytes beyond
        for (int i = 0; i < 26; i++) exp_q.push_back(pbyte(24'(i)));
        frame(frc_pkg::KIND_PARAM, 8'h00, 24'h00_0000, 8'h1A, 0);
        repeat (4) begin
            ra = 24'($urandom_range(0, 30));
            for (int i = 0; i < 3; i++) exp_q.push_back(pbyte(ra + 24'(i)));
            frame(frc_pkg::KIND_PARAM, 8'h00, ra, 8'h03, 0);
        end
        for (int i = 15; i >= 0; i--) exp_q.push_back(UIDV[8*i +: 8]);
        frame(frc_pkg::KIND_UID, 8'h00, 24'h00_0000, 8'h10, 0);
        // Host cuts a read short after two bytes
        exp_q.push_back(pbyte(24'h00_0004));
        exp_q.push_back(pbyte(24'h00_0005));
        frame(frc_pkg::KIND_PARAM, 8'h00, 24'h00_0004, 8'h08, 2);
        check(exp_q.size(), 0);
        check(lnk.so_line, 1'b1);
        // Armed reset during a program aborts it
        prog_busy = 1'b1;
        frame(frc_pkg::KIND_OPCODE, `FRC_OP_ARM, 24'h00_0000, 8'h00, 0);
        check(armed, 1'b1);
        frame(frc_pkg::KIND_OPCODE, `FRC_OP_RST, 24'h00_0000, 8'h00, 0);
        check(n_rst, 1);
        check(n_abort, 1);
        check(armed, 1'b0);
        prog_busy = 1'b0;
        // Each of four opcodes other than arm (00h, 4Bh, 5Ah, 9Fh) between arm and reset disarms
        foreach (CANCEL[j]) begin
            frame(frc_pkg::KIND_OPCODE, `FRC_OP_ARM, 24'h00_0000, 8'h00, 0);
            frame(frc_pkg::KIND_OPCODE, CANCEL[j], 24'h00_0000, 8'h00, 0);
            check(cmd_opcode, CANCEL[j]);
            check(armed, 1'b0);
            frame(frc_pkg::KIND_OPCODE, `FRC_OP_RST, 24'h00_0000, 8'h00, 0);
            check(n_rst, 1);
        end
        frame(frc_pkg::KIND_OPCODE, `FRC_OP_ARM, 24'h00_0000, 8'h00, 0);
        frame(frc_pkg::KIND_OPCODE, `FRC_OP_RST, 24'h00_0000, 8'h00, 0);
        check(n_rst, 2);
        check(n_abort, 1);
        // One opcode byte completes in each of the 23 frames
        check(n_cmd, 23);
        give_verdict();
    end
endmodule // flash_reset_uid_sfdp_cmds_tb_top
`default_nettype wire
